// ===== rtl/cst_params.svh
// Purpose: constants of the charge stage threshold and temperature fault block
// Assumes: register offsets are byte addresses on the serial register port
// Notes:   one step of a stage threshold code is 0.5 percent of stage-2 voltage
`ifndef CST_PARAMS_SVH
`define CST_PARAMS_SVH
`define CST_OFS_UP_THR      8'h3e
`define CST_OFS_DN_THR      8'h3f
`define CST_OFS_LO_TEMP     8'h40
`define CST_OFS_HI_TEMP     8'h41
`define CST_OFS_FAULT_STAT  8'h42
`define CST_OFS_MISC        8'h43
`define CST_RST_UP_THR      8'h8c
`define CST_RST_DN_THR      8'h84
`define CST_RST_LO_TEMP     8'h80
`define CST_RST_HI_TEMP     8'h7f
`define CST_RST_MISC        8'h00
`define CST_THR_SCALE       8'hc8
`define CST_THR_MAX         8'hb4
`define CST_HYST_DEGC       8'h05
`define CST_TEMP_OFF_LO     8'h80
`define CST_TEMP_OFF_HI     8'h7f
`define CST_BIT_TC          0
`define CST_BIT_COLD        0
`define CST_BIT_HOT         1
`endif

// ===== rtl/cst_pkg.sv
// Purpose: types of the charge stage threshold and temperature fault block
// Assumes: 8-bit register port, 16-bit voltage measurements
// Notes:   state and carriers only
package cst_pkg;
  typedef enum logic [1:0] {
    CST_TRICKLE,
    CST_CC,
    CST_CV,
    CST_REDUCED_CV
  } cst_stage_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cst_reg_req_t;

  typedef struct packed {
    logic [15:0] vbat;
    logic [15:0] stage2_voltage;
    logic [7:0]  battery_temp_input;
  } cst_meas_t;
endpackage

// ===== rtl/cst_thr_scale.sv
// Purpose: turns a threshold code into an absolute voltage
// Assumes: code is twice the percentage of stage-2 voltage
// Notes:   purely combinational; the divide is by a constant
`timescale 1ns/1ps
`include "cst_params.svh"
module cst_thr_scale (
  // code and reference
  input  wire logic [7:0]  code,
  input  wire logic [15:0] stage2_voltage,
  // scaled threshold
  output logic [15:0]      level
);
  logic [23:0] prod;
  logic [23:0] quot;
  always_comb begin
    // 0.5 percent per step: level = v * code / 200
    prod  = 24'(stage2_voltage) * 24'(code);
    quot  = prod / 24'(`CST_THR_SCALE);
    // levels past 16 bits saturate instead of wrapping to a low level
    level = (quot[23:16] != 8'h00) ? '1 : quot[15:0];
  end
endmodule

// ===== rtl/cst_stage_ctrl.sv
// Purpose: stage thresholds and battery temperature fault flags
// Assumes: measurements are synchronous samples taken every clock
// Notes:   registers reached by the serial register port's byte access
`timescale 1ns/1ps
`include "cst_params.svh"
module cst_stage_ctrl
  import cst_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // register port
  input  cst_pkg::cst_reg_req_t reg_req,
  output logic [7:0]           reg_rdata,
  // measurements and charge progress
  input  cst_pkg::cst_meas_t   meas,
  input  wire logic [15:0]     comp_stage2_voltage,
  input  wire logic            cv_reached,
  input  wire logic            enter_reduced_cv,
  // status
  output cst_pkg::cst_stage_t  stage,
  output logic                 cold_battery_flag,
  output logic                 hot_battery_flag,
  output logic                 algo_restart,
  output logic                 temp_comp_on
);
  import cst_pkg::*;

  typedef struct packed {
    logic [7:0]  up_thr;
    logic [7:0]  dn_thr;
    logic [7:0]  lo_temp;
    logic [7:0]  hi_temp;
    logic [7:0]  misc;
    logic        cold;
    logic        hot;
    logic        restart;
    cst_stage_t  stage;
    logic [7:0]  rdata;
  } cst_state_t;

  cst_state_t st_r;
  cst_state_t st_nxt;

  logic [15:0] ref_v;
  logic [15:0] up_level;
  logic [15:0] dn_level;
  logic signed [8:0] temp_s;
  logic signed [8:0] lo_s;
  logic signed [8:0] hi_s;
  logic signed [8:0] hyst_s;

  // compensated reference only when compensation is enabled
  assign ref_v = st_r.misc[`CST_BIT_TC] ? comp_stage2_voltage
                                        : meas.stage2_voltage;

  cst_thr_scale u_up (
    .code           (st_r.up_thr),
    .stage2_voltage (ref_v),
    .level          (up_level)
  );

  cst_thr_scale u_dn (
    .code           (st_r.dn_thr),
    .stage2_voltage (ref_v),
    .level          (dn_level)
  );

  // sign extension to nine bits keeps the hysteresis sums from wrapping
  assign temp_s = {meas.battery_temp_input[7], meas.battery_temp_input};
  assign lo_s   = {st_r.lo_temp[7], st_r.lo_temp};
  assign hi_s   = {st_r.hi_temp[7], st_r.hi_temp};
  assign hyst_s = {1'b0, `CST_HYST_DEGC};

  always_comb begin
    st_nxt = st_r;
    st_nxt.restart = 1'b0;
    // register writes; codes above 0xb4 are stored as written
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        `CST_OFS_UP_THR:  st_nxt.up_thr  = reg_req.wdata;
        `CST_OFS_DN_THR:  st_nxt.dn_thr  = reg_req.wdata;
        `CST_OFS_LO_TEMP: st_nxt.lo_temp = reg_req.wdata;
        `CST_OFS_HI_TEMP: st_nxt.hi_temp = reg_req.wdata;
        `CST_OFS_MISC:    st_nxt.misc    = reg_req.wdata;
        default: ;
      endcase
    end
    // read data captured each cycle; unmapped offsets read zero
    unique case (reg_req.addr)
      `CST_OFS_UP_THR:     st_nxt.rdata = st_r.up_thr;
      `CST_OFS_DN_THR:     st_nxt.rdata = st_r.dn_thr;
      `CST_OFS_LO_TEMP:    st_nxt.rdata = st_r.lo_temp;
      `CST_OFS_HI_TEMP:    st_nxt.rdata = st_r.hi_temp;
      `CST_OFS_MISC:       st_nxt.rdata = st_r.misc;
      `CST_OFS_FAULT_STAT: st_nxt.rdata = {6'h00, st_r.hot, st_r.cold};
      default:             st_nxt.rdata = 8'h00;
    endcase
    // cold fault with hysteresis; -128 limit never trips
    if (st_r.lo_temp == `CST_TEMP_OFF_LO) begin
      st_nxt.cold = 1'b0;
    end else if (temp_s <= lo_s) begin
      st_nxt.cold = 1'b1;
    end else if (temp_s > lo_s + hyst_s) begin
      st_nxt.cold = 1'b0;
    end
    // hot fault with hysteresis; 127 limit never trips
    if (st_r.hi_temp == `CST_TEMP_OFF_HI) begin
      st_nxt.hot = 1'b0;
    end else if (temp_s >= hi_s) begin
      st_nxt.hot = 1'b1;
    end else if (temp_s < hi_s - hyst_s) begin
      st_nxt.hot = 1'b0;
    end
    // stage selection from the scaled thresholds
    unique case (st_r.stage)
      CST_TRICKLE: begin
        if (meas.vbat >= up_level) begin
          st_nxt.stage = CST_CC;
        end
      end
      CST_CC: begin
        if (meas.vbat < dn_level) begin
          st_nxt.stage = CST_TRICKLE;
        end else if (cv_reached) begin
          st_nxt.stage = CST_CV;
        end
      end
      CST_CV, CST_REDUCED_CV: begin
        if (meas.vbat < dn_level) begin
          st_nxt.stage   = CST_TRICKLE;
          st_nxt.restart = 1'b1;
        end else if (st_r.stage == CST_CV && enter_reduced_cv) begin
          st_nxt.stage = CST_REDUCED_CV;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.up_thr  <= `CST_RST_UP_THR;
      st_r.dn_thr  <= `CST_RST_DN_THR;
      st_r.lo_temp <= `CST_RST_LO_TEMP;
      st_r.hi_temp <= `CST_RST_HI_TEMP;
      st_r.misc    <= `CST_RST_MISC;
      st_r.cold    <= 1'b0;
      st_r.hot     <= 1'b0;
      st_r.restart <= 1'b0;
      st_r.stage   <= CST_TRICKLE;
      st_r.rdata   <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata         = st_r.rdata;
  assign stage             = st_r.stage;
  assign cold_battery_flag = st_r.cold;
  assign hot_battery_flag  = st_r.hot;
  assign algo_restart      = st_r.restart;
  assign temp_comp_on      = st_r.misc[`CST_BIT_TC];

  // a disabled limit never raises a flag
  a_cold_disabled: assert property (
    @(posedge clk) disable iff (rst)
    $past(st_r.lo_temp) == `CST_TEMP_OFF_LO && !$past(rst)
    |-> !st_r.cold)
    else $error("cold flag set with low limit disabled");

  a_hot_disabled: assert property (
    @(posedge clk) disable iff (rst)
    $past(st_r.hi_temp) == `CST_TEMP_OFF_HI && !$past(rst)
    |-> !st_r.hot)
    else $error("hot flag set with high limit disabled");

  // flags set on the next edge, hold inside the band, clear past it
  a_cold_sets: assert property (
    @(posedge clk) disable iff (rst)
    st_r.lo_temp != `CST_TEMP_OFF_LO && temp_s <= lo_s
    |=> st_r.cold)
    else $error("cold flag missed at low limit");

  a_hot_sets: assert property (
    @(posedge clk) disable iff (rst)
    st_r.hi_temp != `CST_TEMP_OFF_HI && temp_s >= hi_s
    |=> st_r.hot)
    else $error("hot flag missed at high limit");

  a_cold_holds: assert property (
    @(posedge clk) disable iff (rst)
    st_r.cold && st_r.lo_temp != `CST_TEMP_OFF_LO
    && temp_s <= lo_s + hyst_s
    |=> st_r.cold)
    else $error("cold flag cleared inside hysteresis band");

  a_hot_holds: assert property (
    @(posedge clk) disable iff (rst)
    st_r.hot && st_r.hi_temp != `CST_TEMP_OFF_HI
    && temp_s >= hi_s - hyst_s
    |=> st_r.hot)
    else $error("hot flag cleared inside hysteresis band");

  a_cold_clears: assert property (
    @(posedge clk) disable iff (rst)
    st_r.cold && temp_s > lo_s + hyst_s
    |=> !st_r.cold)
    else $error("cold flag stuck above hysteresis band");

  a_hot_clears: assert property (
    @(posedge clk) disable iff (rst)
    st_r.hot && temp_s < hi_s - hyst_s
    |=> !st_r.hot)
    else $error("hot flag stuck below hysteresis band");

  // status bits mirror the flags one edge after the offset is presented
  a_status_read: assert property (
    @(posedge clk) disable iff (rst)
    reg_req.addr == `CST_OFS_FAULT_STAT
    |=> reg_rdata == {6'h00, $past(st_r.hot), $past(st_r.cold)})
    else $error("fault status does not mirror the flags");

  a_up_write: assert property (
    @(posedge clk) disable iff (rst)
    reg_req.wr && reg_req.addr == `CST_OFS_UP_THR
    |=> st_r.up_thr == $past(reg_req.wdata))
    else $error("up threshold write lost");

  a_dn_write: assert property (
    @(posedge clk) disable iff (rst)
    reg_req.wr && reg_req.addr == `CST_OFS_DN_THR
    |=> st_r.dn_thr == $past(reg_req.wdata))
    else $error("down threshold write lost");

  a_lo_write: assert property (
    @(posedge clk) disable iff (rst)
    reg_req.wr && reg_req.addr == `CST_OFS_LO_TEMP
    |=> st_r.lo_temp == $past(reg_req.wdata))
    else $error("low limit write lost");

  a_hi_write: assert property (
    @(posedge clk) disable iff (rst)
    reg_req.wr && reg_req.addr == `CST_OFS_HI_TEMP
    |=> st_r.hi_temp == $past(reg_req.wdata))
    else $error("high limit write lost");

  // stage moves
  a_trickle_up: assert property (
    @(posedge clk) disable iff (rst)
    st_r.stage == CST_TRICKLE && meas.vbat >= up_level
    |=> st_r.stage == CST_CC)
    else $error("no move to constant current at up threshold");

  a_trickle_holds: assert property (
    @(posedge clk) disable iff (rst)
    st_r.stage == CST_TRICKLE && meas.vbat < up_level
    |=> st_r.stage == CST_TRICKLE)
    else $error("left trickle below up threshold");

  a_cc_down: assert property (
    @(posedge clk) disable iff (rst)
    st_r.stage == CST_CC && meas.vbat < dn_level
    |=> st_r.stage == CST_TRICKLE)
    else $error("no return to trickle below down threshold");

  a_cc_no_restart: assert property (
    @(posedge clk) disable iff (rst)
    st_r.stage == CST_CC |=> !algo_restart)
    else $error("restart pulse on return from constant current");

  a_cv_restart: assert property (
    @(posedge clk) disable iff (rst)
    (st_r.stage == CST_CV || st_r.stage == CST_REDUCED_CV)
    && meas.vbat < dn_level
    |=> algo_restart && st_r.stage == CST_TRICKLE ##1 !algo_restart)
    else $error("charging not restarted below down threshold");

  a_restart_source: assert property (
    @(posedge clk) disable iff (rst)
    algo_restart |-> st_r.stage == CST_TRICKLE
    && ($past(st_r.stage) == CST_CV || $past(st_r.stage) == CST_REDUCED_CV))
    else $error("restart pulse outside constant voltage stages");

  // scaled levels are the floor of reference times code over the scale
  a_ref_select: assert property (
    @(posedge clk) disable iff (rst)
    temp_comp_on && st_r.up_thr <= `CST_THR_MAX
    |-> 32'(up_level) * 32'(`CST_THR_SCALE)
        <= 32'(comp_stage2_voltage) * 32'(st_r.up_thr)
    && 32'(comp_stage2_voltage) * 32'(st_r.up_thr)
        < (32'(up_level) + 32'h1) * 32'(`CST_THR_SCALE))
    else $error("up level does not follow compensated voltage");

  a_ref_plain: assert property (
    @(posedge clk) disable iff (rst)
    !temp_comp_on && st_r.up_thr <= `CST_THR_MAX
    |-> 32'(up_level) * 32'(`CST_THR_SCALE)
        <= 32'(meas.stage2_voltage) * 32'(st_r.up_thr)
    && 32'(meas.stage2_voltage) * 32'(st_r.up_thr)
        < (32'(up_level) + 32'h1) * 32'(`CST_THR_SCALE))
    else $error("up level does not follow stage-2 voltage");

  a_dn_scaled: assert property (
    @(posedge clk) disable iff (rst)
    st_r.dn_thr <= `CST_THR_MAX
    |-> 32'(dn_level) * 32'(`CST_THR_SCALE)
        <= 32'(ref_v) * 32'(st_r.dn_thr)
    && 32'(ref_v) * 32'(st_r.dn_thr)
        < (32'(dn_level) + 32'h1) * 32'(`CST_THR_SCALE))
    else $error("down level off the code scale");
endmodule

// ===== sim/cst_host_model.sv
// Purpose: host side of the register port, one byte per access
// Assumes: requests change at the falling edge, sampled at the rising edge
// Notes:   released write data shows its inverse so stale data is not trusted
`timescale 1ns/1ps
module cst_host_model (
  // clock
  input  wire logic             clk,
  // register port
  output cst_pkg::cst_reg_req_t req,
  input  wire logic [7:0]       rdata
);
  import cst_pkg::*;
  initial req = '{wr: 1'b0, addr: 8'h00, wdata: 8'h00};
  // callers keep threshold codes within 0x00..0xb4
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    req.wr    = 1'b0;
    req.wdata = ~d;
  endtask
  // read data is registered, so it is taken one edge after addr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req.addr = a;
    @(negedge clk);
    d = rdata;
  endtask
endmodule

// ===== sim/test_cst_stage_ctrl.sv
// Purpose: self-checking bench of the stage and temperature fault block
// Assumes: stage2 voltage 20000 counts, compensated value 20000 counts, then 10000 counts
// Notes:   inputs change at the falling edge only
`timescale 1ns/1ps
module test_cst_stage_ctrl;
  import cst_pkg::*;
  logic          clk              = 1'b0;
  logic          rst              = 1'b1;
  logic [15:0]   comp_v           = 16'h4e20;
  logic          cv_reached       = 1'b0;
  logic          enter_reduced_cv = 1'b0;
  cst_meas_t     meas = '{16'h0000, 16'h4e20, 8'h80};
  cst_reg_req_t  reg_req;
  logic [7:0]    reg_rdata;
  cst_stage_t    stage;
  logic          cold, hot, restart, tc_on;
  logic [7:0]    rb;
  int            err_total   = 0;
  int            check_count = 0;
  logic [7:0] ra [6] = '{8'h3e, 8'h3f, 8'h40, 8'h41, 8'h43, 8'h50};
  logic [7:0] rv [6] = '{8'h8c, 8'h84, 8'h80, 8'h7f, 8'h00, 8'h00};
  logic [7:0] tt [8] = '{8'hec, 8'hf0, 8'hf1, 8'hf2,
                         8'h23, 8'h1f, 8'h1e, 8'h1d};
  logic [7:0] tf [8] = '{8'h01, 8'h01, 8'h01, 8'h00,
                         8'h02, 8'h02, 8'h02, 8'h00};

  always #5 clk = ~clk;

  cst_stage_ctrl i_cst_stage_ctrl (
    .clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .meas(meas), .comp_stage2_voltage(comp_v), .cv_reached(cv_reached),
    .enter_reduced_cv(enter_reduced_cv), .stage(stage),
    .cold_battery_flag(cold), .hot_battery_flag(hot),
    .algo_restart(restart), .temp_comp_on(tc_on)
  );
  cst_host_model i_cst_host_model (
    .clk(clk), .req(reg_req), .rdata(reg_rdata)
  );

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic step(input logic [15:0] v, input logic [7:0] t);
    @(negedge clk);
    meas.vbat               = v;
    meas.battery_temp_input = t;
    @(negedge clk);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // whole run is under a hundred cycles; the limit leaves wide margin
  initial begin
    #20us;
    err_total++;
    stop_test();
  end

  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      i_cst_host_model.rd(ra[i], rb);
      chk("reset value", rv[i], rb);
    end
    step(16'h0000, 8'h80);
    chk("cold at -128 limit", 8'h00, {7'h00, cold});
    step(16'h0000, 8'h7f);
    chk("hot at 127 limit", 8'h00, {7'h00, hot});
    // status register is read only
    i_cst_host_model.wr(8'h42, 8'hff);
    i_cst_host_model.rd(8'h42, rb);
    chk("status write ignored", 8'h00, rb);
    // threshold writes land; codes stay inside 0x00..0xb4
    i_cst_host_model.wr(8'h3e, 8'h6f);
    i_cst_host_model.rd(8'h3e, rb);
    chk("up threshold", 8'h6f, rb);
    i_cst_host_model.wr(8'h3f, 8'hb4);
    i_cst_host_model.rd(8'h3f, rb);
    chk("down threshold", 8'hb4, rb);
    // up 70 percent, down 66 percent: host keeps 4 percent apart
    i_cst_host_model.wr(8'h3e, 8'h8c);
    i_cst_host_model.wr(8'h3f, 8'h84);
    step(16'h36af, 8'h00);
    chk("stage below up", 8'h00, {6'h00, stage});
    step(16'h36b0, 8'h00);
    chk("stage at up", 8'h01, {6'h00, stage});
    step(16'h3390, 8'h00);
    chk("stage at down", 8'h01, {6'h00, stage});
    step(16'h338f, 8'h00);
    chk("stage below down", 8'h00, {6'h00, stage});
    step(16'h36b0, 8'h00);
    cv_reached = 1'b1;
    @(negedge clk);
    chk("stage cv", 8'h02, {6'h00, stage});
    enter_reduced_cv = 1'b1;
    @(negedge clk);
    chk("stage reduced cv", 8'h03, {6'h00, stage});
    step(16'h338f, 8'h00);
    chk("restart stage", 8'h00, {6'h00, stage});
    chk("restart pulse", 8'h01, {7'h00, restart});
    cv_reached       = 1'b0;
    enter_reduced_cv = 1'b0;
    @(negedge clk);
    chk("restart pulse end", 8'h00, {7'h00, restart});
    // without compensation 7000 stays far below the up level
    step(16'h1b58, 8'h00);
    chk("uncomp at 7000", 8'h00, {6'h00, stage});
    // drop under 7000 first, else the enable itself moves the stage
    step(16'h1b57, 8'h00);
    // compensated stage2 halves, so the up level drops to 7000
    comp_v = 16'h2710;
    i_cst_host_model.wr(8'h43, 8'h01);
    chk("comp enable", 8'h01, {7'h00, tc_on});
    step(16'h1b57, 8'h00);
    chk("comp below up", 8'h00, {6'h00, stage});
    step(16'h1b58, 8'h00);
    chk("comp at up", 8'h01, {6'h00, stage});
    // limits -20 and 35, low kept below high
    i_cst_host_model.wr(8'h40, 8'hec);
    i_cst_host_model.wr(8'h41, 8'h23);
    for (int i = 0; i < 8; i++) begin
      step(16'h1b58, tt[i]);
      chk("fault flags", tf[i], {6'h00, hot, cold});
    end
    step(16'h1b58, 8'hec);
    i_cst_host_model.rd(8'h42, rb);
    chk("status cold", 8'h01, rb);
    step(16'h1b58, 8'h23);
    i_cst_host_model.rd(8'h42, rb);
    chk("status hot", 8'h02, rb);
    stop_test();
  end
endmodule
